// [osd_pin_pkg.sv]
package osd_pin_pkg;

  // Pin mapping selection, one-hot coded.
  typedef enum logic [1:0] {
    MAP_SEPARATE = 2'b01,
    MAP_RGB3BLK  = 2'b10
  } pin_map_e;

  // Mapping taken after reset, before any setting command arrives.
  localparam pin_map_e MAP_RESET = MAP_SEPARATE;

  // Field position of the one-hot bit that means per-colour blanking.
  localparam int MAP_RGB3_BIT = 1;

  // Number of flip-flops on each asynchronous pin input.
  localparam int PIN_SYNC_STAGES = 3;

  // Reset levels of the filtered pin inputs (pins idle high or grounded).
  localparam logic SYNC_IDLE_N   = 1'b1;
  localparam logic TEST_IDLE     = 1'b0;

  // Level driven on every pin output while the test mode is set.
  localparam logic TEST_DRIVE    = 1'b1;

endpackage

// [pin_sync.sv]
// Three-stage synchroniser with agreement filter for one pin input.
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Asynchronous pin and its filtered level.
  input  wire logic pin_i,
  output logic      level_o
);

  logic [osd_pin_pkg::PIN_SYNC_STAGES-1:0] stage_q;

  // Shift chain; only the second stage reads the first.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stage_q <= {osd_pin_pkg::PIN_SYNC_STAGES{RST_VAL}};
    end
    else
    begin
      stage_q <= {stage_q[osd_pin_pkg::PIN_SYNC_STAGES-2:0], pin_i};
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      level_o <= RST_VAL;
    end
    else if (stage_q[1] == stage_q[2])
    begin
      level_o <= stage_q[2];
    end
  end

endmodule

// [pin_route.sv]
// Combinational output multiplexer; one select bit moves all pins at once.
module pin_route (
  // Mapping select: high for per-colour blanking.
  input  wire logic rgb3_sel_i,
  // Colour character and blanking signals.
  input  wire logic red_char_i,
  input  wire logic green_char_i,
  input  wire logic blue_char_i,
  input  wire logic red_blank_i,
  input  wire logic green_blank_i,
  input  wire logic blue_blank_i,
  // Separate channel signals.
  input  wire logic ch1_char_i,
  input  wire logic ch1_blank_i,
  input  wire logic ch2_char_i,
  input  wire logic ch2_blank_i,
  // Shared pin values.
  output logic      pin11_o,
  output logic      pin12_o,
  output logic      pin13_o,
  output logic      pin14_o,
  output logic      pin15_o
);

  logic any_blank;
  logic any_char;

  // Blanking and character sums over the three colours.
  assign any_blank = red_blank_i | green_blank_i | blue_blank_i;
  assign any_char  = red_char_i | green_char_i | blue_char_i;

  // Selection is purely combinational so no pin lags another.
  always_comb
  begin
    if (rgb3_sel_i)
    begin
      pin11_o = any_blank;
      pin12_o = any_char;
      pin13_o = red_blank_i;
      pin14_o = green_blank_i;
      pin15_o = blue_blank_i;
    end
    else
    begin
      pin11_o = ch1_blank_i;
      pin12_o = ch1_char_i;
      pin13_o = ch2_blank_i;
      pin14_o = ch2_char_i;
      pin15_o = any_blank;
    end
  end

endmodule

// [osd_output_pin_mapping.sv]
module osd_output_pin_mapping (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Colour character and blanking signals from the character generator.
  input  wire logic red_char_i,
  input  wire logic green_char_i,
  input  wire logic blue_char_i,
  input  wire logic red_blank_i,
  input  wire logic green_blank_i,
  input  wire logic blue_blank_i,
  // Channel signals already routed by the row selection logic.
  input  wire logic ch1_char_i,
  input  wire logic ch1_blank_i,
  input  wire logic ch2_char_i,
  input  wire logic ch2_blank_i,
  // Pin selection from the initial status setting decoder.
  input  wire logic map_set_i,
  input  wire logic map_rgb3_i,
  // Asynchronous pins.
  input  wire logic test_pin_i,
  input  wire logic vsync_n_i,
  input  wire logic hsync_n_i,
  // Colour character pins.
  output logic      red_char_out_o,
  output logic      green_char_out_o,
  output logic      blue_char_out_o,
  // Shared pins, named by the separate-channel meaning.
  output logic      first_channel_blank_out_o,
  output logic      first_char_channel_out_o,
  output logic      second_channel_blank_out_o,
  output logic      second_char_channel_out_o,
  output logic      common_colour_blank_out_o,
  // Status towards the rest of the device.
  output logic      map_rgb3_o,
  output logic      test_mode_o,
  output logic      vsync_o,
  output logic      hsync_o
);

  osd_pin_pkg::pin_map_e map_q;
  osd_pin_pkg::pin_map_e map_d;
  logic                  rgb3_sel;
  logic                  test_lvl;
  logic                  vsync_n_lvl;
  logic                  hsync_n_lvl;
  logic                  pin11;
  logic                  pin12;
  logic                  pin13;
  logic                  pin14;
  logic                  pin15;

  // Filtered pin inputs; the sync pins idle high, the test pin low.
  pin_sync #(
    .RST_VAL (osd_pin_pkg::TEST_IDLE)
  ) u_test_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (test_pin_i),
    .level_o   (test_lvl)
  );

  pin_sync #(
    .RST_VAL (osd_pin_pkg::SYNC_IDLE_N)
  ) u_vsync_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (vsync_n_i),
    .level_o   (vsync_n_lvl)
  );

  pin_sync #(
    .RST_VAL (osd_pin_pkg::SYNC_IDLE_N)
  ) u_hsync_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (hsync_n_i),
    .level_o   (hsync_n_lvl)
  );

  // Next mapping: a setting command replaces it, otherwise it holds.
  always_comb
  begin
    map_d = map_q;
    if (map_set_i)
    begin
      map_d = map_rgb3_i ? osd_pin_pkg::MAP_RGB3BLK
                         : osd_pin_pkg::MAP_SEPARATE;
    end
  end

  // Mapping state; reset lands on the separate-channel mapping.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      map_q <= osd_pin_pkg::MAP_RESET;
    end
    else
    begin
      map_q <= map_d;
    end
  end

  // One bit drives the whole multiplexer; an illegal code falls back.
  always_comb
  begin
    case (map_q)
      osd_pin_pkg::MAP_RGB3BLK:  rgb3_sel = 1'b1;
      osd_pin_pkg::MAP_SEPARATE: rgb3_sel = 1'b0;
      default:                   rgb3_sel = 1'b0;
    endcase
  end

  pin_route u_route (
    .rgb3_sel_i    (rgb3_sel),
    .red_char_i    (red_char_i),
    .green_char_i  (green_char_i),
    .blue_char_i   (blue_char_i),
    .red_blank_i   (red_blank_i),
    .green_blank_i (green_blank_i),
    .blue_blank_i  (blue_blank_i),
    .ch1_char_i    (ch1_char_i),
    .ch1_blank_i   (ch1_blank_i),
    .ch2_char_i    (ch2_char_i),
    .ch2_blank_i   (ch2_blank_i),
    .pin11_o       (pin11),
    .pin12_o       (pin12),
    .pin13_o       (pin13),
    .pin14_o       (pin14),
    .pin15_o       (pin15)
  );

  // Test mode follows only the filtered pin, so a grounded pin keeps it off.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      test_mode_o <= 1'b0;
    end
    else
    begin
      test_mode_o <= test_lvl;
    end
  end

  // Pin registers; all shared pins load on one edge so mappings never mix.
  // Test mode forces every pin high as a simple lamp test of the board.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      red_char_out_o             <= 1'b0;
      green_char_out_o           <= 1'b0;
      blue_char_out_o            <= 1'b0;
      first_channel_blank_out_o  <= 1'b0;
      first_char_channel_out_o   <= 1'b0;
      second_channel_blank_out_o <= 1'b0;
      second_char_channel_out_o  <= 1'b0;
      common_colour_blank_out_o  <= 1'b0;
    end
    else if (test_mode_o)
    begin
      red_char_out_o             <= osd_pin_pkg::TEST_DRIVE;
      green_char_out_o           <= osd_pin_pkg::TEST_DRIVE;
      blue_char_out_o            <= osd_pin_pkg::TEST_DRIVE;
      first_channel_blank_out_o  <= osd_pin_pkg::TEST_DRIVE;
      first_char_channel_out_o   <= osd_pin_pkg::TEST_DRIVE;
      second_channel_blank_out_o <= osd_pin_pkg::TEST_DRIVE;
      second_char_channel_out_o  <= osd_pin_pkg::TEST_DRIVE;
      common_colour_blank_out_o  <= osd_pin_pkg::TEST_DRIVE;
    end
    else
    begin
      red_char_out_o             <= red_char_i;
      green_char_out_o           <= green_char_i;
      blue_char_out_o            <= blue_char_i;
      first_channel_blank_out_o  <= pin11;
      first_char_channel_out_o   <= pin12;
      second_channel_blank_out_o <= pin13;
      second_char_channel_out_o  <= pin14;
      common_colour_blank_out_o  <= pin15;
    end
  end

  // Mapping status, registered alongside the pins it describes.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      map_rgb3_o <= 1'b0;
    end
    else
    begin
      map_rgb3_o <= map_q[osd_pin_pkg::MAP_RGB3_BIT];
    end
  end

  // Sync pins are negative-going; inverted here so downstream sees pulses
  // as active high. A positive sync source would look active except during its pulses.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vsync_o <= 1'b0;
      hsync_o <= 1'b0;
    end
    else
    begin
      vsync_o <= ~vsync_n_lvl;
      hsync_o <= ~hsync_n_lvl;
    end
  end

  // Checks wait one edge past reset; the releasing edge still loads zeros.
  logic live_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
    end
  end

  // Checks on the pin mapping, one cycle from inputs to pins.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i || !live_q);

  property p_rgb3_first_blank;
    (map_q == osd_pin_pkg::MAP_RGB3BLK) && !test_mode_o |=>
      first_channel_blank_out_o ==
      ($past(red_blank_i) | $past(green_blank_i) | $past(blue_blank_i));
  endproperty
  a_rgb3_first_blank: assert property (p_rgb3_first_blank)
    else $error("First blank pin is not the OR of colour blanks.");

  property p_rgb3_first_char;
    (map_q == osd_pin_pkg::MAP_RGB3BLK) && !test_mode_o |=>
      first_char_channel_out_o ==
      ($past(red_char_i) | $past(green_char_i) | $past(blue_char_i));
  endproperty
  a_rgb3_first_char: assert property (p_rgb3_first_char)
    else $error("First channel pin is not the OR of colour characters.");

  property p_rgb3_red_blank;
    (map_q == osd_pin_pkg::MAP_RGB3BLK) && !test_mode_o |=>
      second_channel_blank_out_o == $past(red_blank_i);
  endproperty
  a_rgb3_red_blank: assert property (p_rgb3_red_blank)
    else $error("Second blank pin missed red blanking.");

  property p_rgb3_green_blank;
    (map_q == osd_pin_pkg::MAP_RGB3BLK) && !test_mode_o |=>
      second_char_channel_out_o == $past(green_blank_i);
  endproperty
  a_rgb3_green_blank: assert property (p_rgb3_green_blank)
    else $error("Second channel pin is not green blanking.");

  property p_rgb3_blue_blank;
    (map_q == osd_pin_pkg::MAP_RGB3BLK) && !test_mode_o |=>
      common_colour_blank_out_o == $past(blue_blank_i);
  endproperty
  a_rgb3_blue_blank: assert property (p_rgb3_blue_blank)
    else $error("Common blank pin is not blue blanking.");

  property p_sep_common_blank;
    (map_q == osd_pin_pkg::MAP_SEPARATE) && !test_mode_o |=>
      common_colour_blank_out_o ==
      ($past(red_blank_i) | $past(green_blank_i) | $past(blue_blank_i));
  endproperty
  a_sep_common_blank: assert property (p_sep_common_blank)
    else $error("Common blank pin does not cover all colours.");

  property p_sep_first_pair;
    (map_q == osd_pin_pkg::MAP_SEPARATE) && !test_mode_o |=>
      (first_channel_blank_out_o == $past(ch1_blank_i)) &&
      (first_char_channel_out_o == $past(ch1_char_i));
  endproperty
  a_sep_first_pair: assert property (p_sep_first_pair)
    else $error("First channel pair is not routed.");

  property p_sep_second_pair;
    (map_q == osd_pin_pkg::MAP_SEPARATE) && !test_mode_o |=>
      (second_channel_blank_out_o == $past(ch2_blank_i)) &&
      (second_char_channel_out_o == $past(ch2_char_i));
  endproperty
  a_sep_second_pair: assert property (p_sep_second_pair)
    else $error("Second channel pair is not routed.");

  property p_colour_chars;
    !test_mode_o |=> {red_char_out_o, green_char_out_o, blue_char_out_o}
      == {$past(red_char_i), $past(green_char_i), $past(blue_char_i)};
  endproperty
  a_colour_chars: assert property (p_colour_chars)
    else $error("Colour character pins do not follow dots.");

  property p_test_grounded;
    !test_pin_i [*5] |=> !test_mode_o [*2];
  endproperty
  a_test_grounded: assert property (p_test_grounded)
    else $error("Test mode set while the test pin is grounded.");

  property p_map_holds;
    !map_set_i |=> $stable(map_q);
  endproperty
  a_map_holds: assert property (p_map_holds)
    else $error("Mapping changed without a setting command.");

  property p_map_together;
    map_set_i && (map_rgb3_i != rgb3_sel) |=>
      (map_rgb3_o == $past(rgb3_sel)) ##1
      (map_rgb3_o == $past(map_rgb3_i, 2));
  endproperty
  a_map_together: assert property (p_map_together)
    else $error("Mapping status did not follow the command in time.");

  // Main scenarios.
  c_to_rgb3:   cover property (map_set_i && map_rgb3_i && !rgb3_sel);
  c_to_sep:    cover property (map_set_i && !map_rgb3_i && rgb3_sel);
  c_test_mode: cover property ($rose(test_mode_o));
  c_vsync:     cover property ($rose(vsync_o));

endmodule

// [osd_sync_source.sv]
// Stand-in for the camera sync source feeding the sync pins.
module osd_sync_source #(
  parameter int H_PERIOD = 24,
  parameter int H_LOW    = 10,
  parameter int V_PERIOD = 96,
  parameter int V_LOW    = 12
) (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Sync pins, idle high.
  output logic      hsync_n_o,
  output logic      vsync_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int h_cnt;
  int v_cnt;

  // Free-running line and field counters; pulses are held long enough
  // to pass the pin filter, since short glitches may be dropped.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      h_cnt     <= 0;
      v_cnt     <= 0;
      hsync_n_o <= 1'b1;
      vsync_n_o <= 1'b1;
    end
    else
    begin
      h_cnt     <= (h_cnt == H_PERIOD - 1) ? 0 : h_cnt + 1;
      v_cnt     <= (v_cnt == V_PERIOD - 1) ? 0 : v_cnt + 1;
      hsync_n_o <= (h_cnt >= H_LOW);
      vsync_n_o <= (v_cnt >= V_LOW);
    end
  end
endmodule

// [osd_output_pin_mapping_tb.sv]
// Random traffic against a reference model of the pin routing.
module osd_output_pin_mapping_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk_i;
  logic       sys_rst_i;
  logic [9:0] dat;
  logic       map_set;
  logic       map_rgb3;
  logic       test_pin;
  logic       hsync_n;
  logic       vsync_n;
  logic [8:0] got_v;
  logic       test_mode;
  logic       hsync_o;
  logic       vsync_o;
  logic [8:0] exp_v;
  logic       map_m;
  logic       chk_en;
  logic       rnd_map;
  logic       hs_prev;
  logic       vs_prev;
  int         hs_cnt;
  int         vs_cnt;
  int         n_fail;
  int         samples_checked;

  osd_output_pin_mapping dut_u (
    .mclk_i                     (mclk_i),
    .sys_rst_i                  (sys_rst_i),
    .red_char_i                 (dat[0]),
    .green_char_i               (dat[1]),
    .blue_char_i                (dat[2]),
    .red_blank_i                (dat[3]),
    .green_blank_i              (dat[4]),
    .blue_blank_i               (dat[5]),
    .ch1_char_i                 (dat[6]),
    .ch1_blank_i                (dat[7]),
    .ch2_char_i                 (dat[8]),
    .ch2_blank_i                (dat[9]),
    .map_set_i                  (map_set),
    .map_rgb3_i                 (map_rgb3),
    .test_pin_i                 (test_pin),
    .vsync_n_i                  (vsync_n),
    .hsync_n_i                  (hsync_n),
    .red_char_out_o             (got_v[8]),
    .green_char_out_o           (got_v[7]),
    .blue_char_out_o            (got_v[6]),
    .first_channel_blank_out_o  (got_v[5]),
    .first_char_channel_out_o   (got_v[4]),
    .second_channel_blank_out_o (got_v[3]),
    .second_char_channel_out_o  (got_v[2]),
    .common_colour_blank_out_o  (got_v[1]),
    .map_rgb3_o                 (got_v[0]),
    .test_mode_o                (test_mode),
    .vsync_o                    (vsync_o),
    .hsync_o                    (hsync_o)
  );

  osd_sync_source sync_u (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .hsync_n_o (hsync_n),
    .vsync_n_o (vsync_n)
  );

  // Expected pins: colours, first blank/char, second blank/char, common.
  function automatic logic [8:0] model(input logic [9:0] d, input logic m);
    logic ob;
    logic oc;
    ob = d[3] | d[4] | d[5];
    oc = d[0] | d[1] | d[2];
    if (m)
      return {d[0], d[1], d[2], ob, oc, d[3], d[4], d[5], 1'b1};
    return {d[0], d[1], d[2], d[7], d[6], d[9], d[8], ob, 1'b0};
  endfunction

  task automatic check_bits(input string what, input logic [8:0] e,
                            input logic [8:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Clock at 25 MHz.
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Model reads the inputs the edge samples, then takes any mapping load,
  // so a new mapping shows one edge later, as the design pipelines it.
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      map_m = 1'b0;
      exp_v = 9'h000;
    end
    else
    begin
      exp_v = model(dat, map_m);
      if (map_set)
        map_m = map_rgb3;
    end
    hs_cnt  = (hsync_n === hs_prev) ? hs_cnt + 1 : 0;
    vs_cnt  = (vsync_n === vs_prev) ? vs_cnt + 1 : 0;
    hs_prev = hsync_n;
    vs_prev = vsync_n;
  end

  // Sync outputs are judged only once the pin has settled past the filter.
  // Reset clears the pins at once, ahead of the edge-driven model.
  always @(negedge mclk_i)
  begin
    if (chk_en && sys_rst_i)
      check_bits("reset pins", 9'h000, got_v);
    else if (chk_en)
    begin
      check_bits("pins", exp_v, got_v);
      if (hs_cnt > 8)
        check_bits("hsync_o", {8'h00, ~hs_prev}, {8'h00, hsync_o});
      if (vs_cnt > 8)
        check_bits("vsync_o", {8'h00, ~vs_prev}, {8'h00, vsync_o});
    end
  end

  task automatic run_random(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      dat      <= 10'($urandom);
      map_set  <= rnd_map && ($urandom_range(3) == 0);
      map_rgb3 <= 1'($urandom);
    end
  endtask

  // Bounded wait for the filtered test pin to reach a level.
  task automatic wait_test(input logic lvl);
    int i;
    for (i = 0; i < 12; i++)
    begin
      @(negedge mclk_i);
      if (test_mode === lvl)
        break;
    end
    check_bits("test_mode_o", {8'h00, lvl}, {8'h00, test_mode});
    if (i == 12)
      give_verdict();
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    dat       = 10'h000;
    map_set   = 1'b0;
    map_rgb3  = 1'b0;
    test_pin  = 1'b0;
    chk_en    = 1'b1;
    rnd_map   = 1'b1;
    n_fail    = 0;
    samples_checked = 0;
    void'($urandom(32'he2af_d984));
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    run_random(300);
    // Test pin raised: every pin is forced high.
    @(posedge mclk_i);
    map_set  <= 1'b0;
    chk_en   <= 1'b0;
    test_pin <= 1'b1;
    wait_test(1'b1);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    check_bits("forced pins", 9'h1fe, {got_v[8:1], 1'b0});
    @(posedge mclk_i);
    test_pin <= 1'b0;
    wait_test(1'b0);
    repeat (3) @(posedge mclk_i);
    chk_en <= 1'b1;
    run_random(300);
    // Select per-colour mapping, then reset in mid-run.
    @(posedge mclk_i);
    map_set  <= 1'b1;
    map_rgb3 <= 1'b1;
    @(posedge mclk_i);
    map_set  <= 1'b0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rnd_map   <= 1'b0;
    run_random(20);
    rnd_map <= 1'b1;
    run_random(200);
    give_verdict();
  end
endmodule
